// [design/cache_ctl_pkg.sv]
// cache control package: register map, field positions, reset values, counts
// assumes byte addresses on a 32-bit register port, one aligned word each
package cache_ctl_pkg;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [31:0] MAIN_CTL_ADDR = 32'hFFFC1000; // cache_main_control
	localparam logic [31:0] LOCK_CTL_ADDR = 32'hFFFC1004; // cache_way_lock_control
	localparam logic [31:0] MAIN_CTL_RST  = 32'h00000000;
	localparam logic [31:0] LOCK_CTL_RST  = 32'h00000000;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int OCE_BIT  = 0;  // ocache_enable
	localparam int WT_BIT   = 1;  // write_policy_select
	localparam int OCF_BIT  = 3;  // ocache_flush
	localparam int ICE_BIT  = 8;  // icache_enable
	localparam int ICF_BIT  = 11; // icache_flush
	localparam int W2LK_BIT = 0;  // way2_locked
	localparam int W2LD_BIT = 1;  // way2_force_load
	localparam int W3LK_BIT = 8;  // way3_locked
	localparam int W3LD_BIT = 9;  // way3_force_load
	localparam int LE_BIT   = 16; // lock_mode_enable

	// bits that hold state; everything else reads zero
	localparam logic [31:0] MAIN_CTL_MASK = 32'h00000103;
	localparam logic [31:0] LOCK_CTL_MASK = 32'h00010303;

	// ------------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------------
	localparam int          IDX_W       = 7;     // 128 entries per way
	localparam logic [6:0]  LAST_IDX    = 7'h7F;
	localparam logic [6:0]  FIRST_IDX   = 7'h00;
	localparam logic [5:0]  RECENCY_RST = 6'h00; // state written by a flush

endpackage

// [design/flush_walker.sv]
// flush walker: steps once through every entry index, one per enabled cycle
// assumes the tag store clears valid, dirty and recency for each index given
`timescale 1ns/10ps
module flush_walker (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst,
	input  wire logic       i_clk_en,
	input  wire logic       i_start,
	output logic            o_busy,
	output logic [6:0]      o_index
);

	logic       busy_q;
	logic       busy_d;
	logic [6:0] idx_q;
	logic [6:0] idx_d;
	logic       at_last;

	// ------------------------------------------------------------------
	// next state: a start restarts the walk from the first index
	// ------------------------------------------------------------------
	assign at_last = (idx_q == cache_ctl_pkg::LAST_IDX);
	assign busy_d  = i_start | (busy_q & ~at_last);
	assign idx_d   = i_start ? cache_ctl_pkg::FIRST_IDX
	               : (busy_q ? idx_q + 7'h01 : idx_q);

	// walk state
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			busy_q <= 1'b0;
			idx_q  <= cache_ctl_pkg::FIRST_IDX;
		end else if (i_clk_en) begin
			busy_q <= busy_d;
			idx_q  <= idx_d;
		end
	end

	assign o_busy  = busy_q;
	assign o_index = idx_q;

endmodule

// [design/cache_control_and_way_lock.sv]
// cache control and way lock: two control registers, flush walkers, victim choice
// assumes a core that holds lookups while a stall is shown and a tag store
// that supplies the six recency bits of the missing entry with the miss
`timescale 1ns/10ps

// Behaviour
// R1 - icache flush write clears valid and recency of all entries; reads zero
// R2 - ocache flush write clears valid, dirty, recency of all entries; reads zero
// R3 - icache enable bit: zero disables, one enables the instruction cache
// R4 - ocache enable bit: zero disables, one enables the operand cache
// R5 - write policy bit: zero write-back, one write-through for operand cache
// R6 - main control resets to zero on power-on and deep standby only
// R7 - lock control resets to zero on power-on and deep standby only
// R8 - reserved bits read zero; software writes only zero there
// R9 - lock enable selects locking; load and lock bits idle otherwise
// R10 - way locking touches only the operand cache
// R11 - locked prefetch miss with way3 load and lock fills way 3
// R12 - locked prefetch miss with way2 load and lock fills way 2
// R13 - all other misses take the victim from the recency state
// R14 - prefetch hit fetches nothing and keeps the hitting entry
// R15 - non-prefetch misses in locking mode avoid locked ways
// R16 - software never sets both load bits at once
// R17 - software changes registers from uncached code and reads back
// R18 - unlocked victim follows fixed recency pattern groups; flush zeroes recency
// R19 - locked ways are never chosen by recency-based victim selection
// R20 - valid means data valid; dirty set only by write-back writes
// R21 - a flush finishes all entries before the next lookup is served
module cache_control_and_way_lock (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	input  wire logic        i_clk_en,
	input  wire logic [31:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic        i_ic_miss,
	input  wire logic [5:0]  i_ic_recency,
	input  wire logic        i_oc_lookup,
	input  wire logic        i_oc_hit,
	input  wire logic        i_oc_prefetch,
	input  wire logic [5:0]  i_oc_recency,
	output logic             o_ic_enable,
	output logic             o_oc_enable,
	output logic             o_oc_write_through,
	output logic             o_oc_dirty_on_write,
	output logic             o_ic_stall,
	output logic             o_oc_stall,
	output logic             o_ic_clear,
	output logic      [6:0]  o_ic_clear_index,
	output logic             o_oc_clear,
	output logic      [6:0]  o_oc_clear_index,
	output logic             o_ic_fill,
	output logic      [1:0]  o_ic_victim_way,
	output logic             o_oc_fill,
	output logic      [1:0]  o_oc_victim_way
);

	// ------------------------------------------------------------------
	// recency decode: pattern groups, with locked ways taken out
	// ------------------------------------------------------------------
	function automatic logic [1:0] pick_way(input logic [5:0] rec,
	                                        input logic       lk2,
	                                        input logic       lk3);
		logic [1:0] way;
		way = 2'h3;
		unique case ({lk3, lk2})
			2'b00: begin
				unique case (rec)
					6'h00, 6'h04, 6'h14, 6'h20, 6'h30, 6'h34: way = 2'h3;
					6'h01, 6'h03, 6'h0B, 6'h21, 6'h29, 6'h2B: way = 2'h2;
					6'h06, 6'h07, 6'h0F, 6'h16, 6'h1E, 6'h1F: way = 2'h1;
					default: way = 2'h0;
				endcase
			end
			2'b01: begin
				unique case (rec)
					6'h00, 6'h01, 6'h04, 6'h14, 6'h20, 6'h21, 6'h30, 6'h34: way = 2'h3;
					6'h03, 6'h06, 6'h07, 6'h0B, 6'h0F, 6'h16, 6'h1E, 6'h1F: way = 2'h1;
					default: way = 2'h0;
				endcase
			end
			2'b10: begin
				unique case (rec)
					6'h00, 6'h01, 6'h03, 6'h0B, 6'h20, 6'h21, 6'h29, 6'h2B: way = 2'h2;
					6'h04, 6'h06, 6'h07, 6'h0F, 6'h14, 6'h16, 6'h1E, 6'h1F: way = 2'h1;
					default: way = 2'h0;
				endcase
			end
			2'b11: begin
				way = rec[5] ? 2'h0 : 2'h1;
			end
		endcase
		return way;
	endfunction

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	logic        ice_q;
	logic        oce_q;
	logic        wt_q;
	logic        le_q;
	logic        w3ld_q;
	logic        w3lk_q;
	logic        w2ld_q;
	logic        w2lk_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        ic_fill_q;
	logic [1:0]  ic_way_q;
	logic        oc_fill_q;
	logic [1:0]  oc_way_q;

	logic        sel_main;
	logic        sel_lock;
	logic        wr_main;
	logic        wr_lock;
	logic        ic_flush_go;
	logic        oc_flush_go;
	logic [31:0] main_view;
	logic [31:0] lock_view;
	logic        ic_busy;
	logic        oc_busy;
	logic        lk2_eff;
	logic        lk3_eff;
	logic        force3;
	logic        force2;
	logic [1:0]  oc_way_d;
	logic        oc_miss;

	// address decode and write strobes
	assign sel_main    = (i_addr == cache_ctl_pkg::MAIN_CTL_ADDR);
	assign sel_lock    = (i_addr == cache_ctl_pkg::LOCK_CTL_ADDR);
	assign wr_main     = i_wr & sel_main;
	assign wr_lock     = i_wr & sel_lock;
	assign ic_flush_go = wr_main & i_wdata[cache_ctl_pkg::ICF_BIT]; // [R1]
	assign oc_flush_go = wr_main & i_wdata[cache_ctl_pkg::OCF_BIT]; // [R2]

	// read views: flush bits and reserved bits always zero
	assign main_view = cache_ctl_pkg::MAIN_CTL_MASK & // [R8]
		{23'h000000, ice_q, 6'h00, wt_q, oce_q}; // [R1] [R2]
	assign lock_view = cache_ctl_pkg::LOCK_CTL_MASK & // [R8]
		{15'h0000, le_q, 6'h00, w3ld_q, w3lk_q, 6'h00, w2ld_q, w2lk_q};
	assign rdata_d = !i_rd   ? 32'h00000000
	               : sel_main ? main_view
	               : sel_lock ? lock_view
	               : 32'h00000000; // unmapped reads return zero

	// main control; only power-on reset clears it
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			ice_q <= cache_ctl_pkg::MAIN_CTL_RST[cache_ctl_pkg::ICE_BIT]; // [R6]
			oce_q <= cache_ctl_pkg::MAIN_CTL_RST[cache_ctl_pkg::OCE_BIT];
			wt_q  <= cache_ctl_pkg::MAIN_CTL_RST[cache_ctl_pkg::WT_BIT];
		end else if (i_clk_en && wr_main) begin
			ice_q <= i_wdata[cache_ctl_pkg::ICE_BIT]; // [R3]
			oce_q <= i_wdata[cache_ctl_pkg::OCE_BIT]; // [R4]
			wt_q  <= i_wdata[cache_ctl_pkg::WT_BIT];  // [R5]
		end
	end

	// lock control; only power-on reset clears it
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			le_q   <= cache_ctl_pkg::LOCK_CTL_RST[cache_ctl_pkg::LE_BIT]; // [R7]
			w3ld_q <= cache_ctl_pkg::LOCK_CTL_RST[cache_ctl_pkg::W3LD_BIT];
			w3lk_q <= cache_ctl_pkg::LOCK_CTL_RST[cache_ctl_pkg::W3LK_BIT];
			w2ld_q <= cache_ctl_pkg::LOCK_CTL_RST[cache_ctl_pkg::W2LD_BIT];
			w2lk_q <= cache_ctl_pkg::LOCK_CTL_RST[cache_ctl_pkg::W2LK_BIT];
		end else if (i_clk_en && wr_lock) begin
			le_q   <= i_wdata[cache_ctl_pkg::LE_BIT];
			w3ld_q <= i_wdata[cache_ctl_pkg::W3LD_BIT];
			w3lk_q <= i_wdata[cache_ctl_pkg::W3LK_BIT];
			w2ld_q <= i_wdata[cache_ctl_pkg::W2LD_BIT];
			w2lk_q <= i_wdata[cache_ctl_pkg::W2LK_BIT];
		end
	end

	// read data, standing only in the cycle after the read strobe
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= 32'h00000000;
		end else if (i_clk_en) begin
			rdata_q <= rdata_d;
		end
	end

	// ------------------------------------------------------------------
	// flush walkers
	// ------------------------------------------------------------------
	flush_walker u_ic_flush (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_clk_en  (i_clk_en),
		.i_start   (ic_flush_go),
		.o_busy    (ic_busy),
		.o_index   (o_ic_clear_index)
	);

	flush_walker u_oc_flush (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_clk_en  (i_clk_en),
		.i_start   (oc_flush_go),
		.o_busy    (oc_busy),
		.o_index   (o_oc_clear_index)
	);

	// each clear resets valid, dirty and recency of one index, no write-back
	assign o_ic_clear = ic_busy; // [R1] [R18]
	assign o_oc_clear = oc_busy; // [R2] [R18]
	assign o_ic_stall = ic_busy; // [R21]
	assign o_oc_stall = oc_busy; // [R21]

	// ------------------------------------------------------------------
	// victim selection
	// ------------------------------------------------------------------
	// lock bits only count in locking mode, and only for the operand cache
	assign lk2_eff  = le_q & w2lk_q;                             // [R9] [R15]
	assign lk3_eff  = le_q & w3lk_q;                             // [R9] [R15]
	assign force3   = i_oc_prefetch & le_q & w3ld_q & w3lk_q & ~w2ld_q; // [R11]
	assign force2   = i_oc_prefetch & le_q & w2ld_q & w2lk_q & ~w3ld_q; // [R12]
	assign oc_miss  = i_oc_lookup & ~i_oc_hit & oce_q & ~oc_busy; // [R14] [R21]
	assign oc_way_d = force3 ? 2'h3                              // [R11]
	                : force2 ? 2'h2                              // [R12]
	                : pick_way(i_oc_recency, lk2_eff, lk3_eff);  // [R13] [R19]

	// fill requests and victim ways
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			ic_fill_q <= 1'b0;
			ic_way_q  <= 2'h0;
			oc_fill_q <= 1'b0;
			oc_way_q  <= 2'h0;
		end else if (i_clk_en) begin
			ic_fill_q <= i_ic_miss & ice_q & ~ic_busy; // [R21]
			oc_fill_q <= oc_miss;                      // [R14]
			if (i_ic_miss) begin
				ic_way_q <= pick_way(i_ic_recency, 1'b0, 1'b0); // [R10] [R18]
			end
			if (oc_miss) begin
				oc_way_q <= oc_way_d;
			end
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign o_rdata             = rdata_q;
	assign o_ic_enable         = ice_q;   // [R3]
	assign o_oc_enable         = oce_q;   // [R4]
	assign o_oc_write_through  = wt_q;    // [R5]
	assign o_oc_dirty_on_write = ~wt_q;   // [R20]
	assign o_ic_fill           = ic_fill_q;
	assign o_ic_victim_way     = ic_way_q;
	assign o_oc_fill           = oc_fill_q;
	assign o_oc_victim_way     = oc_way_q;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_flush_bits_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R1]
		(i_clk_en && i_rd && sel_main) |=> (o_rdata[11] == 1'b0 && o_rdata[3] == 1'b0))
		else $error("flush bits read as one");

	a_reserved_read_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R8]
		(i_clk_en && i_rd && sel_lock) |=> ((o_rdata & ~cache_ctl_pkg::LOCK_CTL_MASK) == 0))
		else $error("reserved lock bits read nonzero");

	a_enables_follow: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R3]
		(i_clk_en && wr_main) |=> (o_ic_enable == $past(i_wdata[8])
		                          && o_oc_enable == $past(i_wdata[0])))
		else $error("cache enables do not follow the write");

	a_policy_follows: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R5]
		(i_clk_en && wr_main) |=> (o_oc_write_through == $past(i_wdata[1])
		                          && o_oc_dirty_on_write != $past(i_wdata[1])))
		else $error("write policy does not follow the write");

	a_flush_stalls: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R21]
		(i_clk_en && oc_flush_go) |=> (o_oc_stall && o_oc_clear && o_oc_clear_index == 7'h00))
		else $error("operand flush did not start");

	a_prefetch_op_way3: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R11]
		(i_clk_en && oc_miss && force3) |=> (o_oc_fill && o_oc_victim_way == 2'h3))
		else $error("forced prefetch miss not placed in way 3");

	a_prefetch_op_way2: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R12]
		(i_clk_en && oc_miss && force2) |=> (o_oc_fill && o_oc_victim_way == 2'h2))
		else $error("forced prefetch miss not placed in way 2");

	a_locked_excluded: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R19]
		(i_clk_en && oc_miss && !force2 && !force3 && le_q && w2lk_q)
		|=> (o_oc_victim_way != 2'h2))
		else $error("locked way 2 chosen as victim");

	a_hit_no_fill: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R14]
		(i_clk_en && i_oc_lookup && i_oc_hit) |=> !o_oc_fill)
		else $error("fill requested on a hit");

	a_icache_unlocked: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R10]
		(i_clk_en && i_ic_miss && ice_q && !ic_busy && i_ic_recency == 6'h00)
		|=> (o_ic_fill && o_ic_victim_way == 2'h3))
		else $error("instruction cache victim affected by locking");

	a_ic_flush_starts: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R1]
		(i_clk_en && ic_flush_go)
		|=> (o_ic_stall && o_ic_clear && o_ic_clear_index == 7'h00))
		else $error("instruction flush did not start");

	a_oc_walk_steps: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R2]
		(i_clk_en && oc_busy && !oc_flush_go && o_oc_clear_index != cache_ctl_pkg::LAST_IDX)
		|=> (o_oc_clear && o_oc_clear_index == $past(o_oc_clear_index) + 7'h01))
		else $error("operand flush skipped an index");

	a_oc_walk_ends: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R21]
		(i_clk_en && oc_busy && !oc_flush_go && o_oc_clear_index == cache_ctl_pkg::LAST_IDX)
		|=> !o_oc_stall)
		else $error("operand flush did not end after the last index");

	a_ic_walk_ends: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R21]
		(i_clk_en && ic_busy && !ic_flush_go && o_ic_clear_index == cache_ctl_pkg::LAST_IDX)
		|=> !o_ic_stall)
		else $error("instruction flush did not end after the last index");

	a_oc_stall_nofill: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R21]
		(i_clk_en && o_oc_stall) |=> !o_oc_fill)
		else $error("operand fill during flush");

	a_ic_stall_nofill: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R21]
		(i_clk_en && o_ic_stall) |=> !o_ic_fill)
		else $error("instruction fill during flush");

	a_oc_off_nofill: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R4]
		(i_clk_en && !o_oc_enable) |=> !o_oc_fill)
		else $error("operand fill while disabled");

	a_ic_off_nofill: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R3]
		(i_clk_en && !o_ic_enable) |=> !o_ic_fill)
		else $error("instruction fill while disabled");

	a_way3_excluded: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R19]
		(i_clk_en && oc_miss && !force2 && !force3 && le_q && w3lk_q)
		|=> (o_oc_victim_way != 2'h3))
		else $error("locked way 3 chosen as victim");

	a_unlocked_recency: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R13]
		(i_clk_en && oc_miss && !le_q && i_oc_recency == 6'h00)
		|=> (o_oc_fill && o_oc_victim_way == 2'h3))
		else $error("unlocked victim does not follow recency");

	a_main_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R8]
		(i_clk_en && i_rd && sel_main)
		|=> ((o_rdata & ~cache_ctl_pkg::MAIN_CTL_MASK) == 32'h00000000))
		else $error("reserved main bits read nonzero");

endmodule

// [bench/core_model.sv]
// core model: issues one icache miss or ocache lookup at a time
// assumes fill and victim way are registered at the taking edge and can be read 1 ns after it
`timescale 1ns/10ps
module core_model (
	input  wire logic       i_sys_clk,
	input  wire logic       i_ic_fill,
	input  wire logic [1:0] i_ic_way,
	input  wire logic       i_oc_fill,
	input  wire logic [1:0] i_oc_way,
	output logic            o_ic_miss,
	output logic      [5:0] o_ic_recency,
	output logic            o_oc_lookup,
	output logic            o_oc_hit,
	output logic            o_oc_prefetch,
	output logic      [5:0] o_oc_recency
);
	// ------------------------------------------------------------------
	// idle values at time zero
	// ------------------------------------------------------------------
	initial begin
		o_ic_miss = 1'b0;
		o_ic_recency = 6'h00;
		o_oc_lookup = 1'b0;
		o_oc_hit = 1'b0;
		o_oc_prefetch = 1'b0;
		o_oc_recency = 6'h00;
	end

	// pulse one access, then release with inverted qualifiers so stale
	// values can never pass for a held request; collect the answer
	task access(input logic ic, hit, prefetch_op, input logic [5:0] rec,
		output logic fill, output logic [1:0] way);
		@(posedge i_sys_clk);
		o_ic_miss <= ic;
		o_oc_lookup <= ~ic;
		o_oc_hit <= hit;
		o_oc_prefetch <= prefetch_op;
		o_ic_recency <= rec;
		o_oc_recency <= rec;
		@(posedge i_sys_clk);
		o_ic_miss <= 1'b0;
		o_oc_lookup <= 1'b0;
		o_oc_hit <= ~hit;
		o_oc_prefetch <= ~prefetch_op;
		o_ic_recency <= ~rec;
		o_oc_recency <= ~rec;
		#1;
		fill = ic ? i_ic_fill : i_oc_fill;
		way = ic ? i_ic_way : i_oc_way;
	endtask
endmodule

// [bench/tb_top.sv]
// testbench top: register port tasks, victim table, flush walk, resets
// assumes the core model in core_model.sv drives the lookup side
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_errors++; \
	$display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module tb_top;
	logic        i_sys_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_clk_en = 1'b1;
	logic [31:0] i_addr = 32'h00000000;
	logic [31:0] i_wdata = 32'h00000000;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [31:0] o_rdata;
	logic        ic_miss, oc_lookup, oc_hit, oc_prefetch_op, ic_fill, oc_fill;
	logic [5:0]  ic_rec, oc_rec;
	logic [1:0]  ic_way, oc_way;
	logic        o_ic_enable, o_oc_enable, o_oc_write_through, o_oc_dirty_on_write;
	logic        o_ic_stall, o_oc_stall, o_ic_clear, o_oc_clear;
	logic [6:0]  o_ic_clear_index, o_oc_clear_index;
	int          n_errors = 0;
	int          compares = 0;
	int          n;
	logic        f;
	logic [1:0]  w;

	// ------------------------------------------------------------------
	// clock, design and core model
	// ------------------------------------------------------------------
	always #20 i_sys_clk = ~i_sys_clk;

	cache_control_and_way_lock u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_clk_en(i_clk_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_ic_miss(ic_miss), .i_ic_recency(ic_rec),
		.i_oc_lookup(oc_lookup), .i_oc_hit(oc_hit), .i_oc_prefetch(oc_prefetch_op),
		.i_oc_recency(oc_rec), .o_ic_enable(o_ic_enable), .o_oc_enable(o_oc_enable),
		.o_oc_write_through(o_oc_write_through),
		.o_oc_dirty_on_write(o_oc_dirty_on_write), .o_ic_stall(o_ic_stall),
		.o_oc_stall(o_oc_stall), .o_ic_clear(o_ic_clear),
		.o_ic_clear_index(o_ic_clear_index), .o_oc_clear(o_oc_clear),
		.o_oc_clear_index(o_oc_clear_index), .o_ic_fill(ic_fill),
		.o_ic_victim_way(ic_way), .o_oc_fill(oc_fill), .o_oc_victim_way(oc_way));

	core_model u_core (.i_sys_clk(i_sys_clk), .i_ic_fill(ic_fill), .i_ic_way(ic_way),
		.i_oc_fill(oc_fill), .i_oc_way(oc_way), .o_ic_miss(ic_miss),
		.o_ic_recency(ic_rec), .o_oc_lookup(oc_lookup), .o_oc_hit(oc_hit),
		.o_oc_prefetch(oc_prefetch_op), .o_oc_recency(oc_rec));

	// ------------------------------------------------------------------
	// register port tasks and checks
	// ------------------------------------------------------------------
	task wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1;
		`CHK("rdata", exp, o_rdata)
	endtask

	// bounded wait for both flush walks to finish
	task wait_idle;
		int k;
		for (k = 0; k < 300 && (o_oc_stall !== 1'b0 || o_ic_stall !== 1'b0); k++) begin
			@(posedge i_sys_clk);
			#1;
		end
		`CHK("idle", 1'b0, o_oc_stall | o_ic_stall)
	endtask

	// set the lock register, read it back, then issue one access
	task vic(input logic [31:0] lk, input logic ic, hit, prefetch_op, input logic [5:0] rec,
		input logic ef, input logic [1:0] ew);
		wr(cache_ctl_pkg::LOCK_CTL_ADDR, lk);
		rd(cache_ctl_pkg::LOCK_CTL_ADDR, lk);
		u_core.access(ic, hit, prefetch_op, rec, f, w);
		`CHK("fill", ef, f)
		if (ef) `CHK("way", ew, w)
	endtask

	// count the clear cycles of a flush walk and follow its index
	task flush_run;
		int k;
		n = 0;
		for (k = 0; k < 200; k++) begin
			#1;
			`CHK("stall", o_oc_clear, o_oc_stall)
			`CHK("ic_clear", o_oc_clear, o_ic_clear)
			if (o_oc_clear === 1'b1) begin
				`CHK("idx", n[6:0], o_oc_clear_index)
				`CHK("ic_idx", n[6:0], o_ic_clear_index)
				n++;
			end
			@(posedge i_sys_clk);
		end
		`CHK("clears", 128, n)
	endtask

	task close_out;
		if (n_errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		repeat (20) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		rd(cache_ctl_pkg::MAIN_CTL_ADDR, 32'h00000000);
		rd(cache_ctl_pkg::LOCK_CTL_ADDR, 32'h00000000);
		wr(cache_ctl_pkg::MAIN_CTL_ADDR, 32'hFFFFFFFF);
		rd(cache_ctl_pkg::MAIN_CTL_ADDR, 32'h00000103);
		`CHK("en", 3'h7, {o_ic_enable, o_oc_enable, o_oc_write_through})
		wait_idle;
		wr(cache_ctl_pkg::LOCK_CTL_ADDR, 32'hFFFFFDFF);
		rd(cache_ctl_pkg::LOCK_CTL_ADDR, 32'h00010103);
		rd(32'hFFFC1008, 32'h00000000);
		vic(32'h00000000, 0, 0, 1, 6'h00, 1, 2'h3);
		vic(32'h00000000, 0, 0, 0, 6'h03, 1, 2'h2);
		vic(32'h00000000, 0, 0, 0, 6'h1E, 1, 2'h1);
		vic(32'h00000000, 0, 0, 0, 6'h39, 1, 2'h0);
		vic(32'h00000300, 0, 0, 1, 6'h38, 1, 2'h0);
		vic(32'h00010300, 0, 0, 1, 6'h3F, 1, 2'h3);
		vic(32'h00010003, 0, 0, 1, 6'h3F, 1, 2'h2);
		vic(32'h00010300, 0, 1, 1, 6'h3F, 0, 2'h0);
		vic(32'h00010300, 0, 0, 0, 6'h00, 1, 2'h2);
		vic(32'h00010001, 0, 0, 1, 6'h03, 1, 2'h1);
		vic(32'h00010001, 0, 0, 0, 6'h01, 1, 2'h3);
		vic(32'h00010001, 0, 0, 0, 6'h29, 1, 2'h0);
		vic(32'h00010100, 0, 0, 0, 6'h04, 1, 2'h1);
		vic(32'h00010101, 0, 0, 0, 6'h00, 1, 2'h1);
		vic(32'h00010101, 0, 0, 0, 6'h20, 1, 2'h0);
		vic(32'h00010101, 1, 0, 0, 6'h01, 1, 2'h2);
		wr(cache_ctl_pkg::MAIN_CTL_ADDR, 32'h00000000);
		vic(32'h00000000, 0, 0, 1, 6'h00, 0, 2'h0);
		vic(32'h00000000, 1, 0, 0, 6'h00, 0, 2'h0);
		`CHK("dis", 3'h0, {o_ic_enable, o_oc_enable, o_oc_write_through})
		wr(cache_ctl_pkg::MAIN_CTL_ADDR, 32'h0000090B);
		flush_run;
		wr(cache_ctl_pkg::MAIN_CTL_ADDR, 32'h00000109);
		u_core.access(0, 0, 0, 6'h00, f, w);
		`CHK("stall_fill", 1'b0, f)
		wait_idle;
		`CHK("dirty", 1'b1, o_oc_dirty_on_write)
		@(posedge i_sys_clk);
		i_clk_en <= 1'b0;
		wr(cache_ctl_pkg::MAIN_CTL_ADDR, 32'h00000000);
		@(posedge i_sys_clk);
		i_clk_en <= 1'b1;
		rd(cache_ctl_pkg::MAIN_CTL_ADDR, 32'h00000101);
		wr(cache_ctl_pkg::LOCK_CTL_ADDR, 32'h00010101);
		rd(cache_ctl_pkg::LOCK_CTL_ADDR, 32'h00010101);
		@(posedge i_sys_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		rd(cache_ctl_pkg::MAIN_CTL_ADDR, 32'h00000000);
		rd(cache_ctl_pkg::LOCK_CTL_ADDR, 32'h00000000);
		`CHK("rst_en", 2'h0, {o_ic_enable, o_oc_enable})
		close_out;
	end

	// cuts a hang short
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		n_errors++;
		close_out;
	end
endmodule
